/* hdl/hstuc_pkg.sv */
/*
 * hstuc_pkg: register map, field positions and reset values of the
 * magnetic switch and temperature configuration bank.
 * Assumes an 8-bit register space reached over a two-wire serial port.
 */
package hstuc_pkg;

    localparam int unsigned NUM_REGS = 8;

    // entry indices into the register array
    localparam int unsigned IDX_MAG_CFG   = 0;
    localparam int unsigned IDX_MAG_PROX  = 1;
    localparam int unsigned IDX_MAG_TOUCH = 2;
    localparam int unsigned IDX_TMP_CFG   = 3;
    localparam int unsigned IDX_TMP_MULT  = 4;
    localparam int unsigned IDX_CAL_A     = 5;
    localparam int unsigned IDX_CAL_B     = 6;
    localparam int unsigned IDX_CAL_C     = 7;

    // register addresses, entry 0 in the low byte
    localparam logic [NUM_REGS-1:0][7:0] REG_ADDR = {
        8'hc4, 8'hc3, 8'hc2, 8'hc1, 8'hc0, 8'ha2, 8'ha1, 8'ha0
    };
    // writable bits; unassigned bits stay zero
    localparam logic [NUM_REGS-1:0][7:0] REG_MASK = {
        8'hff, 8'hff, 8'hff, 8'h3f, 8'h7f, 8'hff, 8'hff, 8'h77
    };
    localparam logic [NUM_REGS-1:0][7:0] REG_RESET = {
        8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h19, 8'h19, 8'h00
    };

    localparam logic [7:0] ADDR_MAG_CFG        = 8'ha0;
    localparam logic [7:0] ADDR_MAG_PROX       = 8'ha1;
    localparam logic [7:0] ADDR_MAG_TOUCH      = 8'ha2;
    localparam logic [7:0] ADDR_TMP_CFG        = 8'hc0;
    localparam logic [7:0] ADDR_TMP_MULT       = 8'hc1;
    localparam logic [7:0] ADDR_SCALE_PACKED   = 8'hc2;
    localparam logic [7:0] ADDR_OFFSET_ORIG    = 8'hc3;
    localparam logic [7:0] ADDR_CAL_MULT_NEW   = 8'hc2;
    localparam logic [7:0] ADDR_CAL_DIV_NEW    = 8'hc3;
    localparam logic [7:0] ADDR_OFFSET_NEW     = 8'hc4;

    // magnetic switch configuration fields
    localparam int unsigned LIN_BIT      = 6;
    localparam int unsigned THYST_HI     = 5;
    localparam int unsigned THYST_LO     = 4;
    localparam int unsigned SWAP_BIT     = 2;
    localparam int unsigned PHYST_HI     = 1;
    localparam int unsigned PHYST_LO     = 0;
    localparam logic [1:0]  TOUCH_SCALE  = 2'h2;

    // temperature configuration fields
    localparam int unsigned RESEED_PROX_BIT = 6;
    localparam int unsigned RESEED_EN_BIT   = 5;
    localparam int unsigned RESEED_THR_HI   = 4;
    localparam int unsigned RESEED_THR_LO   = 0;
    localparam int unsigned COARSE_HI       = 5;
    localparam int unsigned COARSE_LO       = 4;
    localparam int unsigned FINE_HI         = 3;
    localparam int unsigned FINE_LO         = 0;
    localparam int unsigned PK_MULT_HI      = 7;
    localparam int unsigned PK_MULT_LO      = 4;
    localparam int unsigned PK_DIV_HI       = 3;
    localparam int unsigned PK_DIV_LO       = 0;

    // serial port
    localparam logic [3:0] BITS_PER_BYTE = 4'h8;
    localparam logic [6:0] DEV_ADDR_DEF  = 7'h2a; // arbitrary bus address

    localparam logic [1:0] KIND_ADDR = 2'h0;
    localparam logic [1:0] KIND_PTR  = 2'h1;
    localparam logic [1:0] KIND_DATA = 2'h2;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_RX,
        ST_ACK,
        ST_TX,
        ST_MACK,
        ST_WAIT
    } hstuc_fsm_t;

endpackage : hstuc_pkg

/* hdl/hstuc_regbank.sv */
/*
 * hstuc_regbank: configuration bank for the magnetic switch and
 * temperature functions, with its own two-wire serial slave port.
 * Assumes scl/sda already synchronous to clk_sys_i and an external
 * open-drain pad resolving sda from sda_oe_o.
 */
//
// Behaviour
// - bit 6 turns output linearization on
// - touch hysteresis none, 1/4, 1/8, 1/16
// - bit 2 inverts reported field direction
// - proximity hysteresis none, 1/4, 1/8, 1/16
// - proximity threshold eight bits, resets to 25
// - touch threshold stored value times four
// - bit 6 allows reseed during proximity
// - bit 5 enables the reseed function
// - reseed threshold equals stored five-bit value
// - coarse bits 5:4, fine bits 3:0
// - original: packed multiplier/divider, each plus one
// - original: offset constant at c3
// - newer: full-byte multiplier, divider; offset c4
`timescale 1ns/1ps

module hstuc_regbank #(
    parameter logic [6:0] DEV_ADDR      = hstuc_pkg::DEV_ADDR_DEF,
    parameter bit         NEWER_VARIANT = 1'b0
) (
    // clock and reset
    input  wire logic        clk_sys_i,
    input  wire logic        reset_i,
    // serial port
    input  wire logic        scl_i,
    input  wire logic        sda_i,
    output logic             sda_o,
    output logic             sda_oe_o,
    // magnetic switch settings
    output logic             lin_mode_o,
    output logic             swap_dir_o,
    output logic [7:0]       prox_thr_o,
    output logic [7:0]       prox_hyst_o,
    output logic [9:0]       touch_thr_o,
    output logic [9:0]       touch_hyst_o,
    // temperature settings
    output logic             reseed_in_prox_o,
    output logic             reseed_en_o,
    output logic [4:0]       reseed_thr_o,
    output logic [1:0]       temperature_channel_coarse_o,
    output logic [3:0]       temperature_channel_fine_o,
    output logic [8:0]       cal_mult_o,
    output logic [8:0]       cal_div_o,
    output logic [7:0]       cal_offset_o
);

    typedef struct packed {
        hstuc_pkg::hstuc_fsm_t                  fsm;
        logic [1:0]                             kind;
        logic [3:0]                             cnt;
        logic [7:0]                             shift;
        logic                                   rw;
        logic [7:0]                             ptr;
        logic                                   oe;
        logic                                   scl_prev;
        logic                                   sda_prev;
        logic [hstuc_pkg::NUM_REGS-1:0][7:0]    regs;
        logic                                   lin;
        logic                                   swap;
        logic [7:0]                             prox_thr;
        logic [7:0]                             prox_hyst;
        logic [9:0]                             touch_thr;
        logic [9:0]                             touch_hyst;
        logic                                   rs_prox;
        logic                                   rs_en;
        logic [4:0]                             rs_thr;
        logic [1:0]                             coarse;
        logic [3:0]                             fine;
        logic [8:0]                             mult;
        logic [8:0]                             div;
        logic [7:0]                             offset;
    } hstuc_state_t;

    hstuc_state_t s_q;
    hstuc_state_t s_d;

    logic scl_rise;
    logic scl_fall;
    logic bus_start;
    logic bus_stop;

    assign scl_rise  = ~s_q.scl_prev & scl_i;
    assign scl_fall  = s_q.scl_prev & ~scl_i;
    assign bus_start = s_q.scl_prev & scl_i & s_q.sda_prev & ~sda_i;
    assign bus_stop  = s_q.scl_prev & scl_i & ~s_q.sda_prev & sda_i;

    // c4 only exists on the newer variant
    function automatic logic entry_live(input int unsigned idx);
        entry_live = (idx != hstuc_pkg::IDX_CAL_C) || NEWER_VARIANT;
    endfunction : entry_live

    function automatic logic [7:0] read_byte(
        input logic [7:0]                          ptr,
        input logic [hstuc_pkg::NUM_REGS-1:0][7:0] regs
    );
        read_byte = 8'h00;
        for (int unsigned i = 0; i < hstuc_pkg::NUM_REGS; i++)
        begin
            if (ptr == hstuc_pkg::REG_ADDR[i] && entry_live(i))
            begin
                read_byte = regs[i];
            end
        end
    endfunction : read_byte

    // fraction of threshold: sel 1..3 shifts by 2..4, sel 0 gives none
    function automatic logic [9:0] hyst(
        input logic [9:0] thr,
        input logic [1:0] sel
    );
        logic [2:0] sh;
        sh = {1'b0, sel} + 3'h1;
        hyst = (sel == 2'h0) ? 10'h000 : (thr >> sh);
    endfunction : hyst

    always_comb
    begin
        logic [7:0]  rd;
        logic [7:0]  cfg;
        logic [7:0]  tcfg;
        logic [7:0]  tmul;
        logic [9:0]  ph;
        s_d = s_q;
        rd  = read_byte(s_q.ptr, s_q.regs);
        cfg  = s_q.regs[hstuc_pkg::IDX_MAG_CFG];
        tcfg = s_q.regs[hstuc_pkg::IDX_TMP_CFG];
        tmul = s_q.regs[hstuc_pkg::IDX_TMP_MULT];
        ph   = 10'h000;
        s_d.scl_prev = scl_i;
        s_d.sda_prev = sda_i;

        if (bus_start)
        begin
            s_d.fsm  = hstuc_pkg::ST_RX;
            s_d.kind = hstuc_pkg::KIND_ADDR;
            s_d.cnt  = 4'h0;
            s_d.oe   = 1'b0;
        end
        else if (bus_stop)
        begin
            s_d.fsm = hstuc_pkg::ST_IDLE;
            s_d.oe  = 1'b0;
        end
        else
        begin
            case (s_q.fsm)
                hstuc_pkg::ST_RX:
                begin
                    if (scl_rise)
                    begin
                        s_d.shift = {s_q.shift[6:0], sda_i};
                        s_d.cnt   = s_q.cnt + 4'h1;
                    end
                    else if (scl_fall && s_q.cnt == hstuc_pkg::BITS_PER_BYTE)
                    begin
                        s_d.fsm = hstuc_pkg::ST_ACK;
                        s_d.oe  = 1'b1;
                        case (s_q.kind)
                            hstuc_pkg::KIND_ADDR:
                            begin
                                s_d.rw = s_q.shift[0];
                                if (s_q.shift[7:1] != DEV_ADDR)
                                begin
                                    s_d.fsm = hstuc_pkg::ST_WAIT;
                                    s_d.oe  = 1'b0;
                                end
                            end
                            hstuc_pkg::KIND_PTR:
                            begin
                                s_d.ptr = s_q.shift;
                            end
                            default:
                            begin
                                // unmapped addresses take the ack but no data
                                for (int unsigned i = 0;
                                     i < hstuc_pkg::NUM_REGS; i++)
                                begin
                                    if (s_q.ptr == hstuc_pkg::REG_ADDR[i]
                                        && entry_live(i))
                                    begin
                                        s_d.regs[i] = s_q.shift
                                            & hstuc_pkg::REG_MASK[i];
                                    end
                                end
                                s_d.ptr = s_q.ptr + 8'h01;
                            end
                        endcase
                    end
                end
                hstuc_pkg::ST_ACK:
                begin
                    if (scl_fall)
                    begin
                        s_d.cnt = 4'h0;
                        if (s_q.rw)
                        begin
                            s_d.fsm   = hstuc_pkg::ST_TX;
                            s_d.shift = rd;
                            s_d.oe    = ~rd[7];
                            s_d.ptr   = s_q.ptr + 8'h01;
                        end
                        else
                        begin
                            s_d.fsm  = hstuc_pkg::ST_RX;
                            s_d.oe   = 1'b0;
                            s_d.kind = (s_q.kind == hstuc_pkg::KIND_ADDR)
                                ? hstuc_pkg::KIND_PTR : hstuc_pkg::KIND_DATA;
                        end
                    end
                end
                hstuc_pkg::ST_TX:
                begin
                    if (scl_rise)
                    begin
                        s_d.cnt = s_q.cnt + 4'h1;
                    end
                    else if (scl_fall)
                    begin
                        s_d.shift = {s_q.shift[6:0], 1'b0};
                        s_d.oe    = ~s_q.shift[6];
                        if (s_q.cnt == hstuc_pkg::BITS_PER_BYTE)
                        begin
                            s_d.fsm = hstuc_pkg::ST_MACK;
                            s_d.oe  = 1'b0;
                        end
                    end
                end
                hstuc_pkg::ST_MACK:
                begin
                    // master nack ends the read; only a stop or start follows
                    if (scl_rise)
                    begin
                        s_d.rw = ~sda_i;
                    end
                    else if (scl_fall)
                    begin
                        s_d.cnt = 4'h0;
                        if (s_q.rw)
                        begin
                            s_d.fsm   = hstuc_pkg::ST_TX;
                            s_d.shift = rd;
                            s_d.oe    = ~rd[7];
                            s_d.ptr   = s_q.ptr + 8'h01;
                        end
                        else
                        begin
                            s_d.fsm = hstuc_pkg::ST_WAIT;
                        end
                    end
                end
                default:
                begin
                    s_d.oe = 1'b0;
                end
            endcase
        end

        // registered views for the sensing logic
        s_d.lin       = cfg[hstuc_pkg::LIN_BIT];
        s_d.swap      = cfg[hstuc_pkg::SWAP_BIT];
        s_d.prox_thr  = s_q.regs[hstuc_pkg::IDX_MAG_PROX];
        ph = hyst({2'h0, s_q.regs[hstuc_pkg::IDX_MAG_PROX]},
                  cfg[hstuc_pkg::PHYST_HI:hstuc_pkg::PHYST_LO]);
        s_d.prox_hyst = ph[7:0];
        s_d.touch_thr = {s_q.regs[hstuc_pkg::IDX_MAG_TOUCH], 2'b00};
        s_d.touch_hyst = hyst(s_d.touch_thr,
            cfg[hstuc_pkg::THYST_HI:hstuc_pkg::THYST_LO]);
        s_d.rs_prox = tcfg[hstuc_pkg::RESEED_PROX_BIT];
        s_d.rs_en   = tcfg[hstuc_pkg::RESEED_EN_BIT];
        s_d.rs_thr  =
            tcfg[hstuc_pkg::RESEED_THR_HI:hstuc_pkg::RESEED_THR_LO];
        s_d.coarse  = tmul[hstuc_pkg::COARSE_HI:hstuc_pkg::COARSE_LO];
        s_d.fine    = tmul[hstuc_pkg::FINE_HI:hstuc_pkg::FINE_LO];
        // all-ones plus one reaches 256; kept 9 bits wide so nothing is lost
        if (NEWER_VARIANT)
        begin
            s_d.mult   = {1'b0, s_q.regs[hstuc_pkg::IDX_CAL_A]}
                + 9'h001;
            s_d.div    = {1'b0, s_q.regs[hstuc_pkg::IDX_CAL_B]}
                + 9'h001;
            s_d.offset = s_q.regs[hstuc_pkg::IDX_CAL_C];
        end
        else
        begin
            s_d.mult = {5'h00, s_q.regs[hstuc_pkg::IDX_CAL_A]
                [hstuc_pkg::PK_MULT_HI:hstuc_pkg::PK_MULT_LO]} + 9'h001;
            s_d.div  = {5'h00, s_q.regs[hstuc_pkg::IDX_CAL_A]
                [hstuc_pkg::PK_DIV_HI:hstuc_pkg::PK_DIV_LO]} + 9'h001;
            s_d.offset = s_q.regs[hstuc_pkg::IDX_CAL_B];
        end
    end

    always_ff @(posedge clk_sys_i)
    begin
        if (reset_i)
        begin
            s_q           <= '0;
            s_q.scl_prev  <= 1'b1;
            s_q.sda_prev  <= 1'b1;
            s_q.regs      <= hstuc_pkg::REG_RESET;
            s_q.prox_thr  <= hstuc_pkg::REG_RESET[hstuc_pkg::IDX_MAG_PROX];
            s_q.touch_thr <=
                {hstuc_pkg::REG_RESET[hstuc_pkg::IDX_MAG_TOUCH], 2'b00};
            s_q.mult      <= 9'h001;
            s_q.div       <= 9'h001;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    // open drain: the pad only ever pulls low
    assign sda_o    = 1'b0;
    assign sda_oe_o = s_q.oe;

    assign lin_mode_o                   = s_q.lin;
    assign swap_dir_o                   = s_q.swap;
    assign prox_thr_o                   = s_q.prox_thr;
    assign prox_hyst_o                  = s_q.prox_hyst;
    assign touch_thr_o                  = s_q.touch_thr;
    assign touch_hyst_o                 = s_q.touch_hyst;
    assign reseed_in_prox_o             = s_q.rs_prox;
    assign reseed_en_o                  = s_q.rs_en;
    assign reseed_thr_o                 = s_q.rs_thr;
    assign temperature_channel_coarse_o = s_q.coarse;
    assign temperature_channel_fine_o   = s_q.fine;
    assign cal_mult_o                   = s_q.mult;
    assign cal_div_o                    = s_q.div;
    assign cal_offset_o                 = s_q.offset;

endmodule : hstuc_regbank

/* tb/hstuc_checker_properties.sv */
/*
 * hstuc_checker: concurrent checks on the configuration bank's ports.
 * Assumes binding to hstuc_regbank in its original variant.
 */
`timescale 1ns/1ps

module hstuc_checker (
    // clock and reset
    input wire logic       clk_sys_i,
    input wire logic       reset_i,
    // serial port
    input wire logic       sda_oe_o,
    // magnetic switch settings
    input wire logic       lin_mode_o,
    input wire logic       swap_dir_o,
    input wire logic [7:0] prox_thr_o,
    input wire logic [7:0] prox_hyst_o,
    input wire logic [9:0] touch_thr_o,
    input wire logic [9:0] touch_hyst_o,
    // temperature settings
    input wire logic       reseed_in_prox_o,
    input wire logic       reseed_en_o,
    input wire logic [4:0] reseed_thr_o,
    input wire logic [1:0] temperature_channel_coarse_o,
    input wire logic [3:0] temperature_channel_fine_o,
    input wire logic [8:0] cal_mult_o,
    input wire logic [8:0] cal_div_o,
    input wire logic [7:0] cal_offset_o
);
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (reset_i);

    a_prox_reset_val: assert property (
        $fell(reset_i) |-> prox_thr_o == 8'h19)
        else $error("proximity threshold not 25 after reset");
    a_touch_reset_val: assert property (
        $fell(reset_i) |-> touch_thr_o == 10'h064 && touch_hyst_o == 10'h000)
        else $error("touch threshold not 100 after reset");
    a_cal_reset_val: assert property (
        $fell(reset_i) |-> cal_mult_o == 9'h001 && cal_div_o == 9'h001
                           && cal_offset_o == 8'h00)
        else $error("calibration outputs wrong after reset");
    a_touch_times_four: assert property (
        touch_thr_o[1:0] == 2'h0)
        else $error("touch threshold not a multiple of four");
    // the fraction registers in the same clock as the threshold; still wait a cycle
    a_touch_hyst_frac: assert property (
        $stable(touch_thr_o) ##1 $stable(touch_thr_o) |-> touch_hyst_o inside
        {10'h000, touch_thr_o >> 2, touch_thr_o >> 3, touch_thr_o >> 4})
        else $error("touch hysteresis not a listed fraction");
    a_prox_hyst_frac: assert property (
        $stable(prox_thr_o) ##1 $stable(prox_thr_o) |-> prox_hyst_o inside
        {8'h00, prox_thr_o >> 2, prox_thr_o >> 3, prox_thr_o >> 4})
        else $error("proximity hysteresis not a listed fraction");
    a_mag_change_acked: assert property (
        !$past(reset_i) && $changed({lin_mode_o, swap_dir_o, prox_thr_o,
        touch_thr_o}) |-> sda_oe_o)
        else $error("magnetic setting moved outside a write");
    a_temp_change_acked: assert property (
        !$past(reset_i) && $changed({reseed_in_prox_o, reseed_en_o,
        reseed_thr_o, temperature_channel_coarse_o, temperature_channel_fine_o,
        cal_mult_o, cal_div_o, cal_offset_o}) |-> sda_oe_o)
        else $error("temperature setting moved outside a write");
    a_cal_range: assert property (
        cal_mult_o inside {[9'h001:9'h010]} && cal_div_o inside {[9'h001:9'h010]})
        else $error("packed calibration factor outside 1 to 16");

    c_lin_on: cover property ($rose(lin_mode_o));
    c_touch_hyst: cover property (touch_hyst_o != 10'h000);
    c_ack: cover property ($rose(sda_oe_o));
endmodule : hstuc_checker

/* tb/hstuc_host_model.sv */
/*
 * hstuc_host_model: two-wire bus master standing in for the host.
 * Assumes a pulled-up data line resolved outside; drives on falling clk.
 */
`timescale 1ns/1ps

module hstuc_host_model #(
    parameter int HALF = 4
) (
    // clock
    input  wire logic clk_i,
    // bus
    input  wire logic sda_i,
    output logic      scl_o,
    output logic      sda_pull_o
);
    // clock line stands high between frames
    initial
    begin
        scl_o = 1'b1;
        sda_pull_o = 1'b0;
    end

    task automatic tick(input int n);
        repeat (n) @(negedge clk_i);
    endtask : tick

    // start, also usable as a repeated start
    task automatic start();
        sda_pull_o = 1'b0;
        tick(HALF);
        scl_o = 1'b1;
        tick(HALF);
        sda_pull_o = 1'b1;
        tick(HALF);
        scl_o = 1'b0;
        tick(1);
    endtask : start

    task automatic stop();
        sda_pull_o = 1'b1;
        tick(HALF);
        scl_o = 1'b1;
        tick(HALF);
        sda_pull_o = 1'b0;
        tick(HALF);
    endtask : stop

    // data moves only while the clock line is low
    task automatic bit_x(input logic b, output logic s);
        sda_pull_o = ~b;
        tick(HALF);
        scl_o = 1'b1;
        tick(HALF);
        s = sda_i;
        scl_o = 1'b0;
        tick(1);
    endtask : bit_x

    // eight bits msb first, then the ninth bit driven as b9
    task automatic byte_x(input logic [7:0] d, input logic b9,
                          output logic [7:0] q, output logic s9);
        for (int i = 7; i >= 0; i--)
            bit_x(d[i], q[i]);
        bit_x(b9, s9);
    endtask : byte_x

    task automatic wr(input logic [6:0] dev, input logic [7:0] a,
                      input logic [7:0] d, output logic ack);
        logic [7:0] q;
        logic       s1;
        logic       s2;
        logic       s3;
        start();
        byte_x({dev, 1'b0}, 1'b1, q, s1);
        byte_x(a, 1'b1, q, s2);
        byte_x(d, 1'b1, q, s3);
        stop();
        ack = ~(s1 | s2 | s3);
    endtask : wr

    // single byte read ends with a refusal so the device waits for stop
    task automatic rd(input logic [6:0] dev, input logic [7:0] a,
                      output logic [7:0] d);
        logic [7:0] q;
        logic       s;
        start();
        byte_x({dev, 1'b0}, 1'b1, q, s);
        byte_x(a, 1'b1, q, s);
        start();
        byte_x({dev, 1'b1}, 1'b1, q, s);
        byte_x(8'hff, 1'b1, d, s);
        stop();
    endtask : rd
endmodule : hstuc_host_model

/* tb/tb_top.sv */
/*
 * tb_top: self-checking bench for hstuc_regbank, original variant.
 * Assumes the host model and a pulled-up data line built here.
 */
`timescale 1ns/1ps

module tb_top;
    logic       clk_sys_i, reset_i, scl_i, sda_i, pull, ack;
    logic       sda_o, sda_oe_o, lin_mode_o, swap_dir_o;
    logic       reseed_in_prox_o, reseed_en_o;
    logic [7:0] prox_thr_o, prox_hyst_o, cal_offset_o, v, q;
    logic [9:0] touch_thr_o, touch_hyst_o;
    logic [4:0] reseed_thr_o;
    logic [1:0] temperature_channel_coarse_o;
    logic [3:0] temperature_channel_fine_o;
    logic [8:0] cal_mult_o, cal_div_o;
    logic [6:0] dev;
    int         errors, tests_run, seed;
    int         m [int];

    assign sda_i = ~(pull | (sda_oe_o & ~sda_o));
    assign dev = hstuc_pkg::DEV_ADDR_DEF;

    initial clk_sys_i = 1'b0;
    always #20 clk_sys_i = ~clk_sys_i;

    hstuc_regbank i_hstuc_regbank (.clk_sys_i, .reset_i, .scl_i, .sda_i,
        .sda_o, .sda_oe_o, .lin_mode_o, .swap_dir_o, .prox_thr_o,
        .prox_hyst_o, .touch_thr_o, .touch_hyst_o, .reseed_in_prox_o,
        .reseed_en_o, .reseed_thr_o, .temperature_channel_coarse_o,
        .temperature_channel_fine_o, .cal_mult_o, .cal_div_o, .cal_offset_o);
    hstuc_host_model i_hstuc_host_model (.clk_i(clk_sys_i), .sda_i,
        .scl_o(scl_i), .sda_pull_o(pull));

    task automatic cmp(input string k, input logic [9:0] g, input int e);
        tests_run++;
        if (g !== 10'(e))
        begin
            errors++;
            $display("[ERR] %0t %s got %h exp %h", $time, k, g, 10'(e));
        end
    endtask : cmp
    task automatic chk_pin(input logic [9:0] g, input int e);
        cmp("pin", g, e);
    endtask : chk_pin
    task automatic chk_rd(input logic [7:0] g, input int e);
        cmp("read", {2'h0, g}, e);
    endtask : chk_rd
    task automatic chk_ack(input logic g, input int e);
        cmp("ack", {9'h000, g}, e);
    endtask : chk_ack

    function automatic int mask(int a);
        case (a)
            'ha0: return 'h77;
            'hc0: return 'h7f;
            'hc1: return 'h3f;
            default: return 'hff;
        endcase
    endfunction : mask
    function automatic int hy(int t, int s);
        return s == 0 ? 0 : t >> (s + 1);
    endfunction : hy

    task automatic model_reset();
        m = '{'ha0: 0, 'ha1: 'h19, 'ha2: 'h19, 'hc0: 0, 'hc1: 0, 'hc2: 0,
              'hc3: 0};
    endtask : model_reset

    task automatic check_all();
        chk_pin(lin_mode_o, m['ha0] >> 6 & 1);
        chk_pin(touch_hyst_o, hy(m['ha2] * 4, m['ha0] >> 4 & 3));
        chk_pin(swap_dir_o, m['ha0] >> 2 & 1);
        chk_pin(prox_hyst_o, hy(m['ha1], m['ha0] & 3));
        chk_pin(prox_thr_o, m['ha1]);
        chk_pin(touch_thr_o, m['ha2] * 4);
        chk_pin(reseed_in_prox_o, m['hc0] >> 6 & 1);
        chk_pin(reseed_en_o, m['hc0] >> 5 & 1);
        chk_pin(reseed_thr_o, m['hc0] & 31);
        chk_pin(temperature_channel_coarse_o, m['hc1] >> 4 & 3);
        chk_pin(temperature_channel_fine_o, m['hc1] & 15);
        chk_pin(cal_mult_o, (m['hc2] >> 4) + 1);
        chk_pin(cal_div_o, (m['hc2] & 15) + 1);
        chk_pin(cal_offset_o, m['hc3]);
        foreach (m[a])
        begin
            i_hstuc_host_model.rd(dev, 8'(a), q);
            chk_rd(q, m[a]);
        end
    endtask : check_all

    task automatic close_out();
        $display("counts: tests_run=%0d errors=%0d", tests_run, errors);
        if (errors == 0 && tests_run > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : close_out

    initial
    begin
        errors = 0;
        tests_run = 0;
        reset_i = 1'b1;
        seed = $urandom(4);
        repeat (12) @(negedge clk_sys_i);
        reset_i = 1'b0;
        model_reset();
        check_all();
        $display("test reset values done");
        // each hysteresis select once, other bits random
        for (int s = 0; s < 4; s++)
        begin
            foreach (m[a])
            begin
                v = 8'($urandom());
                if (a == 'ha0)
                    v = (v & 8'hcc) | 8'(s * 'h11);
                if (a == 'hc2 && v[7:4] == 4'hf)
                    v[7:4] = 4'he;
                if (a == 'hc2 && v[3:0] == 4'hf)
                    v[3:0] = 4'he;
                i_hstuc_host_model.wr(dev, 8'(a), v, ack);
                chk_ack(ack, 1);
                m[a] = v & mask(a);
            end
            check_all();
        end
        $display("test field sweep done");
        // unmapped place and a foreign device address
        i_hstuc_host_model.wr(dev, 8'hc4, 8'h5a, ack);
        chk_ack(ack, 1);
        i_hstuc_host_model.rd(dev, 8'hc4, q);
        chk_rd(q, 0);
        i_hstuc_host_model.wr(dev ^ 7'h01, 8'ha1, 8'h3c, ack);
        chk_ack(ack, 0);
        check_all();
        $display("test refusals done");
        // reset in mid run restores every default
        @(negedge clk_sys_i);
        reset_i = 1'b1;
        repeat (2) @(negedge clk_sys_i);
        reset_i = 1'b0;
        model_reset();
        check_all();
        $display("test second reset done");
        close_out();
    end

    initial
    begin
        repeat (60000) @(posedge clk_sys_i);
        errors++;
        close_out();
    end
endmodule : tb_top

bind hstuc_regbank hstuc_checker i_hstuc_checker (.clk_sys_i, .reset_i,
    .sda_oe_o, .lin_mode_o, .swap_dir_o, .prox_thr_o, .prox_hyst_o,
    .touch_thr_o, .touch_hyst_o, .reseed_in_prox_o, .reseed_en_o,
    .reseed_thr_o, .temperature_channel_coarse_o,
    .temperature_channel_fine_o, .cal_mult_o, .cal_div_o, .cal_offset_o);
